// ==== hw/tcw_pkg.sv ====
package tcw_pkg;

  // Register offsets (byte addresses).
  localparam logic [7:0] OFS_CONTROL     = 8'h00;
  localparam logic [7:0] OFS_MODE        = 8'h04;
  localparam logic [7:0] OFS_LIVE_COUNT  = 8'h10;
  localparam logic [7:0] OFS_COMPARE_A   = 8'h14;
  localparam logic [7:0] OFS_COMPARE_B   = 8'h18;
  localparam logic [7:0] OFS_COMPARE_C   = 8'h1C;
  localparam logic [7:0] OFS_STATUS      = 8'h20;

  // Control command bits.
  localparam int CTL_CLOCK_ENABLE  = 0;
  localparam int CTL_CLOCK_DISABLE = 1;
  localparam int CTL_SOFT_TRIGGER  = 2;

  // Mode register field positions (low bit of each field).
  localparam int MODE_CLOCK_SELECT   = 0;
  localparam int MODE_EDGE_INVERT    = 3;
  localparam int MODE_GATE_SELECT    = 4;
  localparam int MODE_STOP_ON_C      = 6;
  localparam int MODE_DISABLE_ON_C   = 7;
  localparam int MODE_EVENT_EDGE     = 8;
  localparam int MODE_EVENT_SOURCE   = 10;
  localparam int MODE_EVENT_TRIGGER  = 12;
  localparam int MODE_COUNT_SHAPE    = 13;
  localparam int MODE_WAVEFORM       = 15;
  localparam int MODE_A_ON_A_MATCH   = 16;
  localparam int MODE_A_ON_C_MATCH   = 18;
  localparam int MODE_A_ON_EVENT     = 20;
  localparam int MODE_A_ON_SOFT      = 22;
  localparam int MODE_B_ON_B_MATCH   = 24;
  localparam int MODE_B_ON_C_MATCH   = 26;
  localparam int MODE_B_ON_EVENT     = 28;
  localparam int MODE_B_ON_SOFT      = 30;

  // Status register bit positions.
  localparam int STAT_CLOCK_ON = 16;
  localparam int STAT_MIRROR_A = 17;
  localparam int STAT_MIRROR_B = 18;

  // Reset values.
  localparam logic [31:0] RST_MODE    = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'h0000;

  localparam logic [15:0] COUNT_TOP = 16'hFFFF;

  typedef enum logic [1:0] {
    TCW_ACT_NONE,
    TCW_ACT_SET,
    TCW_ACT_CLEAR,
    TCW_ACT_TOGGLE
  } tcw_action_t;

endpackage

// ==== hw/tcw_channel.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - Counter ticks from one of five divided or three external clocks, edge selectable.
// - Gating field ANDs the selected clock with external input 0, 1 or 2.
// - Stop-on-C bit stops the counter clock when the counter reaches C.
// - Disable-on-C bit disables the counter clock when the counter reaches C.
// - Event edge field picks none, rising, falling or both edges.
// - Event source picks line B or external input 0, 1 or 2.
// - With line B as event source, line B becomes an input and is released.
// - Without event trigger enable, events only drive the programmed line actions.
// - With event trigger enable, each event resets the counter and clears the stop state; the clock enable is unchanged.
// - Count shape selects up or up-down, each with or without C-match trigger.
// - Waveform bit enables waveform operation; field layout follows this bit.
// - Compare A match applies its action to line A.
// - Compare C match applies its own action to line A.
// - External event applies its action to line A.
// - Software trigger applies its action to line A.
// - Compare B match applies its action to line B.
// - Compare C match applies its own action to line B.
// - External event applies its action to line B.
// - Software trigger applies its action to line B.
// - Live count register returns the 16-bit counter, upper bits zero.
// - Compare A is always readable, writable only in waveform operation.
// - Compare B is always readable, writable only in waveform operation.
// - Compare C is always readable and writable.
// - Writing 1 to the soft trigger command resets the counter and clears the stop state; it does not enable the clock.
module tcw_channel (
  input  wire logic        i_core_clk,   // Core clock, 250 MHz.
  input  wire logic        i_srst,       // Synchronous reset, active high.
  input  wire logic [7:0]  i_addr,       // Register byte address.
  input  wire logic [31:0] i_wdata,      // Register write data.
  input  wire logic        i_wr,         // Write strobe.
  input  wire logic        i_rd,         // Read strobe.
  output logic      [31:0] o_rdata,      // Read data, valid the cycle after i_rd.
  input  wire logic [4:0]  i_div_clk,    // Internal divided clocks 1 to 5.
  input  wire logic [2:0]  i_ext_clk,    // External clock inputs 0 to 2.
  output logic             o_io_a,       // Line A output level.
  output logic             o_io_a_oe_n,  // Line A output enable, low drives.
  input  wire logic        i_io_b,       // Line B pin level.
  output logic             o_io_b,       // Line B output level.
  output logic             o_io_b_oe_n   // Line B output enable, low drives.
);

  // Two-stage synchronisers: bits 4..0 divided clocks, 7..5 external, 8 line B.
  logic [8:0]  sync1_q;
  logic [8:0]  sync2_q;

  logic [31:0] mode_q;
  logic [31:0] mode_d;
  logic [15:0] cmp_a_q;
  logic [15:0] cmp_a_d;
  logic [15:0] cmp_b_q;
  logic [15:0] cmp_b_d;
  logic [15:0] cmp_c_q;
  logic [15:0] cmp_c_d;
  logic [31:0] rdata_d;

  logic [15:0] count_q;
  logic [15:0] count_d;
  logic        down_q;
  logic        down_d;
  logic        clk_on_q;
  logic        clk_on_d;
  logic        stopped_q;
  logic        stopped_d;
  logic        moved_q;
  logic        moved_d;
  logic        gclk_q;
  logic        gclk_d;
  logic        evt_q;
  logic        evt_d;
  logic        line_a_q;
  logic        line_a_d;
  logic        line_b_q;
  logic        line_b_d;

  logic [2:0]  clk_sel;
  logic [1:0]  gate_sel;
  logic [1:0]  evt_edge;
  logic [1:0]  evt_src;
  logic [1:0]  shape;
  logic        wave;
  logic [7:0]  src_all;
  logic        sel_clk;
  logic        gate;
  logic        tick;
  logic        evt_now;
  logic        evt_hit;
  logic        soft_trig;
  logic        trig;
  logic        run;
  logic        match_a;
  logic        match_b;
  logic        match_c;
  logic [15:0] top;

  assign clk_sel  = mode_q[tcw_pkg::MODE_CLOCK_SELECT +: 3];
  assign gate_sel = mode_q[tcw_pkg::MODE_GATE_SELECT +: 2];
  assign evt_edge = mode_q[tcw_pkg::MODE_EVENT_EDGE +: 2];
  assign evt_src  = mode_q[tcw_pkg::MODE_EVENT_SOURCE +: 2];
  assign shape    = mode_q[tcw_pkg::MODE_COUNT_SHAPE +: 2];
  assign wave     = mode_q[tcw_pkg::MODE_WAVEFORM];

  // Applies one action to a line level.
  function automatic logic act_apply(input logic cur, input logic [1:0] act);
    logic res;
    res = cur;
    case (tcw_pkg::tcw_action_t'(act))
      tcw_pkg::TCW_ACT_SET:    res = 1'b1;
      tcw_pkg::TCW_ACT_CLEAR:  res = 1'b0;
      tcw_pkg::TCW_ACT_TOGGLE: res = ~cur;
      default:                 res = cur;
    endcase
    return res;
  endfunction

  // Picks the highest-priority active request with a non-null action.
  function automatic logic line_next(
    input logic       cur,
    input logic       m1,
    input logic [1:0] a1,
    input logic       m2,
    input logic [1:0] a2,
    input logic       ev,
    input logic [1:0] ae,
    input logic       sw,
    input logic [1:0] as
  );
    logic res;
    res = cur;
    if (sw && as != 2'b00) begin
      res = act_apply(cur, as);
    end else if (ev && ae != 2'b00) begin
      res = act_apply(cur, ae);
    end else if (m2 && a2 != 2'b00) begin
      res = act_apply(cur, a2);
    end else if (m1 && a1 != 2'b00) begin
      res = act_apply(cur, a1);
    end
    return res;
  endfunction

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      sync1_q <= 9'h000;
      sync2_q <= 9'h000;
    end else begin
      sync1_q <= {i_io_b, i_ext_clk, i_div_clk};
      sync2_q <= sync1_q;
    end
  end

  // Counter clock: selection, gating and edge choice.
  assign src_all = sync2_q[7:0];
  assign sel_clk = src_all[clk_sel];
  always_comb begin
    case (gate_sel)
      2'd1:    gate = sync2_q[5];
      2'd2:    gate = sync2_q[6];
      2'd3:    gate = sync2_q[7];
      default: gate = 1'b1;
    endcase
  end
  assign gclk_d = sel_clk & gate;
  assign tick   = mode_q[tcw_pkg::MODE_EDGE_INVERT] ? (gclk_q & ~gclk_d)
                                                    : (~gclk_q & gclk_d);

  // External event source and edge detection.
  always_comb begin
    case (evt_src)
      2'd1:    evt_now = sync2_q[5];
      2'd2:    evt_now = sync2_q[6];
      2'd3:    evt_now = sync2_q[7];
      default: evt_now = sync2_q[8];
    endcase
  end
  assign evt_d = evt_now;
  always_comb begin
    case (evt_edge)
      2'd1:    evt_hit = ~evt_q & evt_now;
      2'd2:    evt_hit = evt_q & ~evt_now;
      2'd3:    evt_hit = evt_q ^ evt_now;
      default: evt_hit = 1'b0;
    endcase
  end

  assign soft_trig = i_wr && i_addr == tcw_pkg::OFS_CONTROL
                     && i_wdata[tcw_pkg::CTL_SOFT_TRIGGER];
  assign trig = soft_trig
                || (evt_hit && mode_q[tcw_pkg::MODE_EVENT_TRIGGER]);
  assign run  = clk_on_q && !stopped_q;

  // Compares look at the counter in the cycle after it takes a new value.
  assign match_a = wave && moved_q && count_q == cmp_a_q;
  assign match_b = wave && moved_q && count_q == cmp_b_q;
  assign match_c = wave && moved_q && count_q == cmp_c_q;

  assign top = shape[1] ? cmp_c_q : tcw_pkg::COUNT_TOP;

  // Counter, direction, clock state.
  always_comb begin
    count_d   = count_q;
    down_d    = down_q;
    moved_d   = 1'b0;
    clk_on_d  = clk_on_q;
    stopped_d = stopped_q;
    if (i_wr && i_addr == tcw_pkg::OFS_CONTROL) begin
      if (i_wdata[tcw_pkg::CTL_CLOCK_DISABLE]) begin
        clk_on_d = 1'b0;
      end else if (i_wdata[tcw_pkg::CTL_CLOCK_ENABLE]) begin
        clk_on_d = 1'b1;
      end
    end
    if (match_c && mode_q[tcw_pkg::MODE_STOP_ON_C]) begin
      stopped_d = 1'b1;
    end
    if (match_c && mode_q[tcw_pkg::MODE_DISABLE_ON_C]) begin
      clk_on_d = 1'b0;
    end
    if (trig) begin
      count_d   = tcw_pkg::RST_COUNT;
      down_d    = 1'b0;
      stopped_d = 1'b0;
      moved_d   = 1'b1;
    end else if (run && tick && wave) begin
      moved_d = 1'b1;
      case (shape)
        2'b10: begin
          count_d = (count_q == cmp_c_q) ? tcw_pkg::RST_COUNT : count_q + 16'h0001;
        end
        2'b01, 2'b11: begin
          if (!down_q && count_q >= top) begin
            down_d  = 1'b1;
            count_d = count_q - 16'h0001;
          end else if (down_q && count_q == 16'h0000) begin
            down_d  = 1'b0;
            count_d = 16'h0001;
          end else begin
            count_d = down_q ? count_q - 16'h0001 : count_q + 16'h0001;
          end
        end
        default: count_d = count_q + 16'h0001;
      endcase
    end
  end

  // Waveform lines.
  always_comb begin
    line_a_d = line_next(line_a_q,
                         match_a, mode_q[tcw_pkg::MODE_A_ON_A_MATCH +: 2],
                         match_c, mode_q[tcw_pkg::MODE_A_ON_C_MATCH +: 2],
                         evt_hit, mode_q[tcw_pkg::MODE_A_ON_EVENT +: 2],
                         soft_trig && wave,
                         mode_q[tcw_pkg::MODE_A_ON_SOFT +: 2]);
    line_b_d = line_next(line_b_q,
                         match_b, mode_q[tcw_pkg::MODE_B_ON_B_MATCH +: 2],
                         match_c, mode_q[tcw_pkg::MODE_B_ON_C_MATCH +: 2],
                         evt_hit, mode_q[tcw_pkg::MODE_B_ON_EVENT +: 2],
                         soft_trig && wave,
                         mode_q[tcw_pkg::MODE_B_ON_SOFT +: 2]);
  end

  assign o_io_a      = line_a_q;
  assign o_io_a_oe_n = ~wave;
  assign o_io_b      = line_b_q;
  assign o_io_b_oe_n = ~(wave && evt_src != 2'b00);

  // Register writes and reads.
  always_comb begin
    mode_d  = mode_q;
    cmp_a_d = cmp_a_q;
    cmp_b_d = cmp_b_q;
    cmp_c_d = cmp_c_q;
    rdata_d = 32'h0000_0000;
    if (i_wr) begin
      case (i_addr)
        tcw_pkg::OFS_MODE:      mode_d = i_wdata;
        tcw_pkg::OFS_COMPARE_A: if (wave) cmp_a_d = i_wdata[15:0];
        tcw_pkg::OFS_COMPARE_B: if (wave) cmp_b_d = i_wdata[15:0];
        tcw_pkg::OFS_COMPARE_C: cmp_c_d = i_wdata[15:0];
        default:                mode_d = mode_q;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        tcw_pkg::OFS_MODE:       rdata_d = mode_q;
        tcw_pkg::OFS_LIVE_COUNT: rdata_d = {16'h0000, count_q};
        tcw_pkg::OFS_COMPARE_A:  rdata_d = {16'h0000, cmp_a_q};
        tcw_pkg::OFS_COMPARE_B:  rdata_d = {16'h0000, cmp_b_q};
        tcw_pkg::OFS_COMPARE_C:  rdata_d = {16'h0000, cmp_c_q};
        tcw_pkg::OFS_STATUS: begin
          rdata_d[tcw_pkg::STAT_CLOCK_ON] = clk_on_q;
          rdata_d[tcw_pkg::STAT_MIRROR_A] = line_a_q;
          rdata_d[tcw_pkg::STAT_MIRROR_B] = wave && evt_src != 2'b00 ? line_b_q : sync2_q[8];
        end
        default:                 rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      mode_q    <= tcw_pkg::RST_MODE;
      cmp_a_q   <= tcw_pkg::RST_COMPARE;
      cmp_b_q   <= tcw_pkg::RST_COMPARE;
      cmp_c_q   <= tcw_pkg::RST_COMPARE;
      o_rdata   <= 32'h0000_0000;
      count_q   <= tcw_pkg::RST_COUNT;
      down_q    <= 1'b0;
      moved_q   <= 1'b0;
      clk_on_q  <= 1'b0;
      stopped_q <= 1'b0;
      gclk_q    <= 1'b0;
      evt_q     <= 1'b0;
      line_a_q  <= 1'b0;
      line_b_q  <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      cmp_a_q   <= cmp_a_d;
      cmp_b_q   <= cmp_b_d;
      cmp_c_q   <= cmp_c_d;
      o_rdata   <= rdata_d;
      count_q   <= count_d;
      down_q    <= down_d;
      moved_q   <= moved_d;
      clk_on_q  <= clk_on_d;
      stopped_q <= stopped_d;
      gclk_q    <= gclk_d;
      evt_q     <= evt_d;
      line_a_q  <= line_a_d;
      line_b_q  <= line_b_d;
    end
  end

endmodule

// ==== verif/tcw_channel_properties.sv ====
`timescale 1ns/1ns
module tcw_channel_props (
  input wire logic        i_core_clk,   // Core clock.
  input wire logic        i_srst,       // Synchronous reset.
  input wire logic [7:0]  i_addr,       // Register address.
  input wire logic [31:0] i_wdata,      // Write data.
  input wire logic        i_wr,         // Write strobe.
  input wire logic        i_rd,         // Read strobe.
  input wire logic [31:0] o_rdata,      // Read data.
  input wire logic        o_io_a,       // Line A level.
  input wire logic        o_io_a_oe_n,  // Line A enable.
  input wire logic        o_io_b,       // Line B level.
  input wire logic        o_io_b_oe_n   // Line B enable.
);
  logic [31:0] mode_q;
  logic [31:0] mode_d;
  logic        mode_wr;
  logic        soft_w;
  assign mode_wr = i_wr && i_addr == tcw_pkg::OFS_MODE;
  assign soft_w = i_wr && i_addr == tcw_pkg::OFS_CONTROL && i_wdata[2] && mode_q[15];
  always_comb begin
    mode_d = mode_wr ? i_wdata : mode_q;
  end
  always_ff @(posedge i_core_clk) begin
    mode_q <= i_srst ? 32'h0 : mode_d;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  property p_rdata_idle; !i_rd |=> o_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_cv_upper; i_rd && i_addr == tcw_pkg::OFS_LIVE_COUNT |=> o_rdata[31:16] == 16'h0;
  endproperty
  a_cv_upper: assert property (p_cv_upper) else $error("count upper bits set");
  property p_oe_a; mode_wr |=> o_io_a_oe_n == !$past(i_wdata[15]); endproperty
  a_oe_a: assert property (p_oe_a) else $error("line A enable wrong");
  property p_oe_b;
    mode_wr |=> o_io_b_oe_n == !($past(i_wdata[15]) && $past(i_wdata[11:10]) != 2'h0);
  endproperty
  a_oe_b: assert property (p_oe_b) else $error("line B enable wrong");
  property p_oe_hold; !mode_wr |=> $stable({o_io_a_oe_n, o_io_b_oe_n}); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
  property p_sw_a_set; soft_w && mode_q[23:22] == 2'h1 |=> o_io_a; endproperty
  a_sw_a_set: assert property (p_sw_a_set) else $error("line A not set");
  property p_sw_a_clr; soft_w && mode_q[23:22] == 2'h2 |=> !o_io_a; endproperty
  a_sw_a_clr: assert property (p_sw_a_clr) else $error("line A not cleared");
  property p_sw_a_tgl; soft_w && mode_q[23:22] == 2'h3 |=> o_io_a != $past(o_io_a); endproperty
  a_sw_a_tgl: assert property (p_sw_a_tgl) else $error("line A not toggled");
  property p_sw_b; soft_w && mode_q[31:30] == 2'h1 && mode_q[11:10] != 2'h0 |=> o_io_b;
  endproperty
  a_sw_b: assert property (p_sw_b) else $error("line B not set");
  property p_rc_rw; i_wr && i_addr == tcw_pkg::OFS_COMPARE_C ##1 i_rd &&
    i_addr == tcw_pkg::OFS_COMPARE_C |=> o_rdata == {16'h0, $past(i_wdata[15:0], 2)};
  endproperty
  a_rc_rw: assert property (p_rc_rw) else $error("compare C readback wrong");
endmodule
bind tcw_channel tcw_channel_props u_props (.i_core_clk(i_core_clk), .i_srst(i_srst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_io_a(o_io_a), .o_io_a_oe_n(o_io_a_oe_n), .o_io_b(o_io_b), .o_io_b_oe_n(o_io_b_oe_n));

// ==== verif/tcw_far_side.sv ====
`timescale 1ns/1ns
module tcw_far_side (
  input  wire logic       i_core_clk,   // Core clock.
  input  wire logic [2:0] i_ext_req,    // Levels wanted on the external inputs.
  input  wire logic       i_pin_lvl,    // Level put on line B while released.
  input  wire logic       i_io_b,       // Line B level from the channel.
  input  wire logic       i_io_b_oe_n,  // Line B enable from the channel.
  output logic      [4:0] o_div_clk,    // Divided clocks 1 to 5.
  output logic      [2:0] o_ext_clk,    // External clock inputs.
  output logic            o_io_b_pin    // Resolved line B level.
);
  logic [6:0] div_q = 7'h0;
  always @(posedge i_core_clk) div_q <= div_q + 7'h1;
  assign o_div_clk = div_q[6:2];
  assign o_ext_clk = i_ext_req;
  assign o_io_b_pin = i_io_b_oe_n ? i_pin_lvl : i_io_b;
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
  logic        clk;
  logic        srst;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic [4:0]  div_clk;
  logic [2:0]  ext_clk;
  logic [2:0]  ext_req;
  logic        pin_lvl;
  logic        io_a;
  logic        io_a_oe_n;
  logic        io_b_pin;
  logic        io_b;
  logic        io_b_oe_n;
  int          err_total;
  int          tests_run;
  int          regs [int];
  int          ea;
  int          eb;
  int          n;
  tcw_channel uut (.i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_div_clk(div_clk), .i_ext_clk(ext_clk), .o_io_a(io_a),
    .o_io_a_oe_n(io_a_oe_n), .i_io_b(io_b_pin), .o_io_b(io_b), .o_io_b_oe_n(io_b_oe_n));
  tcw_far_side u_far (.i_core_clk(clk), .i_ext_req(ext_req), .i_pin_lvl(pin_lvl),
    .i_io_b(io_b), .i_io_b_oe_n(io_b_oe_n), .o_div_clk(div_clk), .o_ext_clk(ext_clk),
    .o_io_b_pin(io_b_pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic int act(input int cur, input int a);
    return (a == 1) ? 1 : (a == 2) ? 0 : (a == 3) ? 1 - cur : cur;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic mw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    if (a == 8'h04 || a == 8'h1C || ((a == 8'h14 || a == 8'h18) && regs[4][15])) begin
      regs[a] = (a == 8'h04) ? d : {16'h0, d[15:0]};
    end
    #1;
  endtask
  // Writes a register and reads it back in the very next cycle.
  task automatic mwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    regs[a] = {16'h0, d[15:0]};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, regs[a]);
  endtask
  task automatic rc(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, regs.exists(a) ? regs[a] : 32'h0);
  endtask
  task automatic lines(input int x, input int y);
    chk({31'h0, io_a}, x);
    chk({31'h0, io_b}, y);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    srst = 1'b1; addr = 8'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    ext_req = 3'h0; pin_lvl = 1'b1; err_total = 0; tests_run = 0; ea = 0; eb = 0;
    regs.delete();
    regs[4] = 0; regs[16] = 0; regs[20] = 0; regs[24] = 0; regs[28] = 0;
    n = $urandom(73);
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      foreach (regs[k]) rc(k[7:0]);
      rc(8'h08);
      mw(8'h14, $urandom);
      mw(8'h18, $urandom);
      mw(8'h1C, $urandom);
      if (r == 0) mw(8'h04, 32'h0000_8000);
    end
    for (int k = 0; k < 4; k++) begin
      mw(8'h04, 32'h0000_8400 | (k << 22) | (k << 30));
      mw(8'h00, 32'h4);
      ea = act(ea, k);
      eb = act(eb, k);
      lines(ea, eb);
      chk({30'h0, io_a_oe_n, io_b_oe_n}, 0);
      rc(8'h10);
    end
    mw(8'h14, 32'h3);
    mw(8'h18, 32'h2);
    mw(8'h1C, 32'h5);
    mw(8'h04, 32'h8D86_8440);
    mw(8'h00, 32'h5);
    n = 0;
    while (io_a !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) err_total++;
    repeat (60) @(posedge clk);
    regs[16] = 5;
    rc(8'h10);
    lines(1, 0);
    ea = 1;
    for (int t = 0; t < 2; t++) begin
      if (t == 1) mw(8'h00, 32'h2);
      mw(8'h04, 32'h1030_8900 | (t << 12));
      ext_req <= 3'h2;
      repeat (12) @(posedge clk);
      ext_req <= 3'h0;
      repeat (12) @(posedge clk);
      ea = act(ea, 3);
      regs[16] = 5 * (1 - t);
      lines(ea, 1);
      rc(8'h10);
    end
    mw(8'h14, 32'h4);
    mwr(8'h1C, 32'h5);
    mw(8'h04, 32'h0080_E080);
    mw(8'h00, 32'h5);
    repeat (80) @(posedge clk);
    regs[16] = 5;
    rc(8'h10);
    regs[32] = 32'h0004_0000;
    rc(8'h20);
    mw(8'h04, 32'h0081_E000);
    mw(8'h00, 32'h1);
    n = 0;
    while (io_a !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) err_total++;
    #1;
    chk({31'h0, io_a}, 1);
    print_verdict();
  end
endmodule
